// ===== rtl/standard_timer_consts.vh
// Register offsets, field positions, encodings and reset values of the timer.
`ifndef STANDARD_TIMER_CONSTS_VH
`define STANDARD_TIMER_CONSTS_VH

`define ADDR_CTRL0      12'h000
`define ADDR_CTRL1      12'h004
`define ADDR_COUNT      12'h008
`define ADDR_CMPA       12'h00C
`define ADDR_CMPP       12'h010
`define ADDR_FLAGS      12'h014

`define CTRL0_RUN       0
`define CTRL0_TRIG_FALL 1

`define CTRL1_CLR       0
`define CTRL1_DPX       1
`define CTRL1_POL       2
`define CTRL1_OC        3
`define CTRL1_FUNC_LO   4
`define CTRL1_FUNC_HI   5
`define CTRL1_MODE_LO   6
`define CTRL1_MODE_HI   7

`define FLAG_A          0
`define FLAG_P          1

`define MODE_CMP        2'h0
`define MODE_CAP        2'h1
`define MODE_PWM        2'h2
`define MODE_TC         2'h3

`define FUNC_NONE       2'h0
`define FUNC_LOW        2'h1
`define FUNC_HIGH       2'h2
`define FUNC_TOGGLE     2'h3
`define FUNC_INACTIVE   2'h0
`define FUNC_ACTIVE     2'h1
`define FUNC_PWM        2'h2
`define FUNC_PULSE      2'h3
`define CAP_RISE        2'h0
`define CAP_FALL        2'h1
`define CAP_BOTH        2'h2
`define CAP_OFF         2'h3

`define RST_CTRL1       8'h00
`define RST_CMPA        16'h0000
`define RST_CMPP        8'h00
`define RST_DATA        32'h0000_0000
`define P_ZERO_SPAN     17'h1_0000
`define P_LOW_ZERO      8'h00
`define CNT_LOW_TOP     8'hFF

`endif

// ===== rtl/pin_sync.v
// Two-flip-flop synchroniser for asynchronous pin inputs.
module pin_sync #(
	parameter WIDTH = 2
) (
	// Clock, reset and enable.
	input  wire             clk,
	input  wire             rst_n,
	input  wire             ce,
	// Raw and synchronised levels.
	input  wire [WIDTH-1:0] d,
	output wire [WIDTH-1:0] q
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else if (ce) begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;

endmodule

// ===== rtl/sticky_flag.v
// Sticky event flag in which a set in the clearing cycle wins.
module sticky_flag (
	// Clock, reset and enable.
	input  wire clk,
	input  wire rst_n,
	input  wire ce,
	// Event and software clear.
	input  wire set,
	input  wire clr,
	output reg  q
);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= 1'b0;
		end else if (ce) begin
			q <= set | (q & ~clr);
		end
	end

endmodule

// ===== rtl/standard_timer.v
// Standard timer: 16-bit up counter with two comparators and an APB slave.
// Function
// [RULE1] Clear-select high: clear on A, only A flag
// [RULE2] Software never programs A to zero here
// [RULE3] Compare mode: only A match moves pin
// [RULE4] A match sets, clears or toggles pin
// [RULE5] Run rising edge loads initial output level
// [RULE6] Mode 11 counts like compare, pin unused
// [RULE7] Software selects PWM with mode and function
// [RULE8] Duty/period select swaps A and P roles
// [RULE9] P means P times 256, zero 65536
// [RULE10] Duty at or above period gives 100%
// [RULE11] PWM sets A and P flags separately
// [RULE12] PWM level, forcing and polarity controls
// [RULE13] PWM counts for fixed levels, ignores clear-select
// [RULE14] Software sets single-pulse function, keeps it
// [RULE15] Trigger edge sets run, starting the pulse
// [RULE16] A match ends pulse and raises flag
// [RULE17] Pulse counter reset only by run rise
// [RULE18] Capture edge latches counter into A value
// [RULE19] Capture counter runs, P match clears it
// [RULE20] Capture function 11 disables capture only
// [RULE21] Compare function decode: none, low, high, toggle
// [RULE22] P compares with upper counter byte only
// [RULE23] Match on equality, flags stay until cleared
//
// The placing of the registers and the APB register port are this design's own decisions.
module standard_timer #(
	parameter AW = 12
) (
	// Clock, reset and clock enable.
	input  wire          ref_clk,
	input  wire          arst_n,
	input  wire          ce,
	// APB slave.
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [AW-1:0] paddr,
	input  wire [31:0]   pwdata,
	output reg  [31:0]   prdata,
	output wire          pready,
	output reg           pslverr,
	// Timer pins.
	input  wire          trigger_clock_pin,
	input  wire          capture_input_pin,
	output reg           timer_out,
	output reg           timer_out_oe
);

`include "standard_timer_consts.vh"

	// Reset release.
	reg  [1:0]  rst_ff;
	wire        rst_n;

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_ff <= 2'h0;
		end else begin
			rst_ff <= {rst_ff[0], 1'b1};
		end
	end

	assign rst_n = rst_ff[1];

	// Pin synchronisation and edge detection.
	wire [1:0]  pins_s;
	reg  [1:0]  pins_prev_q;
	wire        trig_s;
	wire        cap_s;
	wire        trig_prev;
	wire        cap_prev;

	pin_sync #(
		.WIDTH (2)
	) u_pin_sync (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.ce    (ce),
		.d     ({capture_input_pin, trigger_clock_pin}),
		.q     (pins_s)
	);

	assign trig_s    = pins_s[0];
	assign cap_s     = pins_s[1];
	assign trig_prev = pins_prev_q[0];
	assign cap_prev  = pins_prev_q[1];

	// State registers.
	reg         run_q;
	reg         run_d;
	reg         run_prev_q;
	reg         trig_fall_q;
	reg  [7:0]  ctrl1_q;
	reg  [15:0] cmpa_q;
	reg  [15:0] cmpa_d;
	reg  [7:0]  cmpp_q;
	reg  [15:0] cnt_q;
	reg  [15:0] cnt_d;
	reg         out_lvl_q;
	reg         out_lvl_d;
	reg         pin_d;
	reg         pwm_active;
	reg  [31:0] rd_d;
	reg         err_d;
	wire        flag_a;
	wire        flag_p;

	// Control field decode.
	wire [1:0]  mode    = ctrl1_q[`CTRL1_MODE_HI:`CTRL1_MODE_LO];
	wire [1:0]  func    = ctrl1_q[`CTRL1_FUNC_HI:`CTRL1_FUNC_LO];
	wire        oc      = ctrl1_q[`CTRL1_OC];
	wire        pol     = ctrl1_q[`CTRL1_POL];
	wire        dpx     = ctrl1_q[`CTRL1_DPX];
	wire        clr_sel = ctrl1_q[`CTRL1_CLR];

	wire        is_cmp   = (mode == `MODE_CMP) | (mode == `MODE_TC);
	wire        is_cap   = (mode == `MODE_CAP);
	wire        is_pmode = (mode == `MODE_PWM);
	wire        is_pulse = is_pmode & (func == `FUNC_PULSE);
	wire        is_pwm   = is_pmode & ~is_pulse;

	// APB decode; the slave answers in the access cycle while enabled.
	wire        setup   = psel & ~penable;
	wire        access  = psel & penable & ce;
	wire        wr      = access & pwrite;
	wire        wr_ctl0 = wr & (paddr == `ADDR_CTRL0);
	wire        wr_ctl1 = wr & (paddr == `ADDR_CTRL1);
	wire        wr_cmpa = wr & (paddr == `ADDR_CMPA);
	wire        wr_cmpp = wr & (paddr == `ADDR_CMPP);
	wire        wr_flag = wr & (paddr == `ADDR_FLAGS);

	assign pready = ce;

	// Counter events.
	wire        run_rise = run_q & ~run_prev_q;
	wire        counting = run_q & ~run_rise;
	wire [7:0]  hi_next  = cnt_q[15:8] + 8'h01;
	wire        a_hit    = counting & (cnt_q == cmpa_q); // [RULE23]
	// P compares the upper byte only, so the match falls where the
	// counter would roll into P times 256; zero gives the overflow.
	wire        p_hit    = counting & (cnt_q[7:0] == `CNT_LOW_TOP) &
	                       (hi_next == cmpp_q); // [RULE22] [RULE9]
	wire [16:0] p_span   = (cmpp_q == `P_LOW_ZERO) ? `P_ZERO_SPAN :
	                       {1'b0, cmpp_q, `P_LOW_ZERO}; // [RULE9]

	wire        trig_edge = trig_fall_q ? (trig_prev & ~trig_s) :
	                                      (~trig_prev & trig_s);
	wire        cap_rise  = ~cap_prev & cap_s;
	wire        cap_fall  = cap_prev & ~cap_s;
	reg         cap_sel;

	always @* begin
		case (func)
			`CAP_RISE: cap_sel = cap_rise;
			`CAP_FALL: cap_sel = cap_fall;
			`CAP_BOTH: cap_sel = cap_rise | cap_fall;
			default:   cap_sel = 1'b0; // [RULE20]
		endcase
	end

	wire        cap_hit = is_cap & run_q & cap_sel; // [RULE18]

	// Flag events.
	wire        set_a = (a_hit & ~is_cap) | cap_hit; // [RULE11] [RULE16]
	wire        set_p = p_hit & (is_cap | is_pwm |
	                    (is_cmp & ~clr_sel)); // [RULE1] [RULE11] [RULE19]

	sticky_flag u_flag_a (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.ce    (ce),
		.set   (set_a),
		.clr   (wr_flag & pwdata[`FLAG_A]),
		.q     (flag_a)
	); // [RULE23]

	sticky_flag u_flag_p (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.ce    (ce),
		.set   (set_p),
		.clr   (wr_flag & pwdata[`FLAG_P]),
		.q     (flag_p)
	); // [RULE23]

	// Counter next value.
	always @* begin
		cnt_d = cnt_q;
		if (run_rise) begin
			cnt_d = 16'h0000; // [RULE17]
		end else if (counting) begin
			if (is_pulse) begin
				cnt_d = cnt_q + 16'h0001; // [RULE17]
			end else if (is_cap) begin
				cnt_d = p_hit ? 16'h0000 : cnt_q + 16'h0001; // [RULE19]
			end else if (is_pwm) begin
				// The clear-select bit is not consulted here.
				cnt_d = (dpx ? a_hit : p_hit) ? 16'h0000 :
				        cnt_q + 16'h0001; // [RULE8] [RULE13]
			end else begin
				cnt_d = (clr_sel ? a_hit : p_hit) ? 16'h0000 :
				        cnt_q + 16'h0001; // [RULE1] [RULE6]
			end
		end
	end

	// Run enable: software write, trigger set, pulse-end clear.
	always @* begin
		run_d = run_q;
		if (wr_ctl0) begin
			run_d = pwdata[`CTRL0_RUN];
		end
		if (is_pulse & trig_edge & ~run_q) begin
			run_d = 1'b1; // [RULE15]
		end
		if (is_pulse & a_hit) begin
			run_d = 1'b0; // [RULE16]
		end
	end

	// Capture writes over a software write in the same cycle.
	always @* begin
		cmpa_d = cmpa_q;
		if (wr_cmpa) begin
			cmpa_d = pwdata[15:0];
		end
		if (cap_hit) begin
			cmpa_d = cnt_q; // [RULE18]
		end
	end

	// Compare-mode output level.
	always @* begin
		out_lvl_d = out_lvl_q;
		if (run_rise) begin
			out_lvl_d = oc; // [RULE5]
		end else if ((mode == `MODE_CMP) & a_hit) begin // [RULE3]
			case (func) // [RULE4] [RULE21]
				`FUNC_LOW:    out_lvl_d = 1'b0;
				`FUNC_HIGH:   out_lvl_d = 1'b1;
				`FUNC_TOGGLE: out_lvl_d = ~out_lvl_q;
				default:      out_lvl_d = out_lvl_q;
			endcase
		end
	end

	// PWM active phase; a duty at or above the period stays active.
	always @* begin
		if (dpx) begin
			pwm_active = (p_span >= {1'b0, cmpa_q}) |
			             ({1'b0, cnt_q} < p_span); // [RULE8] [RULE10]
		end else begin
			pwm_active = ({1'b0, cmpa_q} >= p_span) |
			             (cnt_q < cmpa_q); // [RULE8] [RULE10]
		end
	end

	// Pin level after polarity.
	always @* begin
		pin_d = 1'b0;
		if (mode == `MODE_CMP) begin
			pin_d = out_lvl_q ^ pol;
		end else if (is_pulse) begin
			pin_d = (run_q ? oc : ~oc) ^ pol; // [RULE15] [RULE16]
		end else if (is_pwm) begin
			case (func) // [RULE12]
				`FUNC_INACTIVE: pin_d = ~oc ^ pol;
				`FUNC_ACTIVE:   pin_d = oc ^ pol;
				default:        pin_d = (pwm_active ? oc : ~oc) ^ pol;
			endcase
		end
	end

	// Read mux, sampled in the setup cycle.
	always @* begin
		rd_d  = `RST_DATA;
		err_d = 1'b0;
		case (paddr)
			`ADDR_CTRL0: rd_d = {30'h0000_0000, trig_fall_q, run_q};
			`ADDR_CTRL1: rd_d = {24'h00_0000, ctrl1_q};
			`ADDR_COUNT: rd_d = {16'h0000, cnt_q};
			`ADDR_CMPA:  rd_d = {16'h0000, cmpa_q};
			`ADDR_CMPP:  rd_d = {24'h00_0000, cmpp_q};
			`ADDR_FLAGS: rd_d = {30'h0000_0000, flag_p, flag_a};
			default:     err_d = 1'b1;
		endcase
	end

	// Clocked state.
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q        <= 1'b0;
			run_prev_q   <= 1'b0;
			trig_fall_q  <= 1'b0;
			ctrl1_q      <= `RST_CTRL1;
			cmpa_q       <= `RST_CMPA;
			cmpp_q       <= `RST_CMPP;
			cnt_q        <= 16'h0000;
			out_lvl_q    <= 1'b0;
			pins_prev_q  <= 2'h0;
			timer_out    <= 1'b0;
			timer_out_oe <= 1'b0;
			prdata       <= `RST_DATA;
			pslverr      <= 1'b0;
		end else if (ce) begin
			run_q       <= run_d;
			run_prev_q  <= run_q;
			cnt_q       <= cnt_d;
			cmpa_q      <= cmpa_d;
			out_lvl_q   <= out_lvl_d;
			pins_prev_q <= pins_s;
			if (wr_ctl0) begin
				trig_fall_q <= pwdata[`CTRL0_TRIG_FALL];
			end
			if (wr_ctl1) begin
				ctrl1_q <= pwdata[7:0];
			end
			if (wr_cmpp) begin
				cmpp_q <= pwdata[7:0];
			end
			timer_out    <= pin_d;
			// Timer/counter and capture modes leave the pin free.
			timer_out_oe <= (mode == `MODE_CMP) | is_pmode; // [RULE6]
			if (setup) begin
				prdata  <= rd_d;
				pslverr <= err_d;
			end
		end
	end

endmodule

// ===== sim/standard_timer_checker.sv
// Checker of the timer pin against the control byte written over the bus.
`include "standard_timer_consts.vh"
module standard_timer_checker #(
	parameter AW = 12
) (
	// Clock, reset and bus.
	input wire logic          ref_clk,
	input wire logic          arst_n,
	input wire logic          ce,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0]   pwdata,
	// Pin.
	input wire logic          timer_out,
	input wire logic          timer_out_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] c1_q;
	logic [2:0] calm_q;
	wire        wr = psel & penable & pwrite & ce;
	wire [1:0]  md = c1_q[7:6];
	wire [1:0]  fn = c1_q[5:4];
	wire        lv = c1_q[3] ^ c1_q[2];
	wire        ok = calm_q == 3'h7;
	// Settings are trusted only once the pin has had time to follow them.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			c1_q <= 8'h00;
			calm_q <= 3'h0;
		end else begin
			if (wr && paddr == `ADDR_CTRL1)
				c1_q <= pwdata[7:0];
			if (wr && paddr < `ADDR_COUNT)
				calm_q <= 3'h0;
			else if (!ok)
				calm_q <= calm_q + 3'h1;
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	a_oe_compare: assert property (
		ok && md == `MODE_CMP |-> timer_out_oe) else $error("pin undriven");
	a_cmp_pin_hold: assert property (
		ok && md == `MODE_CMP && fn == `FUNC_NONE |-> $stable(timer_out))
		else $error("pin moved");
	a_tc_pin_free: assert property (
		ok && md == `MODE_TC |-> !timer_out_oe) else $error("pin driven");
	a_tc_out_low: assert property (
		ok && md == `MODE_TC |-> !timer_out ##1 !timer_out)
		else $error("pin high");
	a_cap_pin_free: assert property (
		ok && md == `MODE_CAP |-> !timer_out_oe) else $error("pin driven");
	a_pwm_pin_driven: assert property (
		ok && md == `MODE_PWM |-> timer_out_oe) else $error("pin undriven");
	a_pwm_force_off: assert property (
		ok && md == `MODE_PWM && fn == `FUNC_INACTIVE |-> timer_out == !lv)
		else $error("pin not inactive");
	a_pwm_force_on: assert property (
		ok && md == `MODE_PWM && fn == `FUNC_ACTIVE |-> timer_out == lv)
		else $error("pin not active");
endmodule
bind standard_timer standard_timer_checker #(.AW(AW)) chk (.ref_clk,
	.arst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .timer_out,
	.timer_out_oe);

// ===== sim/pin_partner.sv
// Far-side driver of the trigger and capture pins.
module pin_partner (
	// Clock.
	input wire logic clk,
	// Pins.
	output logic     trig,
	output logic     cap
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		trig = 1'b0;
		cap = 1'b0;
	end
	// A level is held for four edges so that the synchroniser sees it.
	task automatic flip(input logic c, input logic v);
		@(posedge clk);
		if (c)
			cap <= v;
		else
			trig <= v;
		repeat (4) @(posedge clk);
	endtask
endmodule

// ===== sim/standard_timer_test.sv
// Self-checking bench of the standard timer.
`include "standard_timer_consts.vh"
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin \
	mismatches++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module standard_timer_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] rd_q;
	logic [31:0] rng = 32'h0000_E827;
	logic [15:0] av;
	logic        err_q;
	wire  [31:0] prdata;
	wire         pready, pslverr, trig, cap, tout;
	int          mismatches = 0;
	int          tests_run = 0;
	int          k, hi, lo, w;
	always #20 ref_clk = ~ref_clk;
	standard_timer dut (.ref_clk, .arst_n, .ce(1'b1), .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.trigger_clock_pin(trig), .capture_input_pin(cap),
		.timer_out(tout), .timer_out_oe());
	pin_partner far (.clk(ref_clk), .trig, .cap);
	function automatic logic [31:0] nxt();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction
	function automatic int span(input logic [7:0] p);
		return (p == `P_LOW_ZERO) ? `P_ZERO_SPAN : {p, 8'h00};
	endfunction
	function automatic int duty(input int i, input int a, input int per);
		int d = (i == 1) ? span(8'h01) : a;
		return (i == 2) ? per - d : d;
	endfunction
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 99);
		if (n == 99) begin
			mismatches++;
			end_of_test();
		end
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Counts the cycles for which the pin keeps the level v.
	task automatic hold_len(input logic v, output int n);
		n = 0;
		while (tout === v && n < 4000) begin
			@(negedge ref_clk);
			n++;
		end
		if (n == 4000) begin
			mismatches++;
			end_of_test();
		end
	endtask
	task automatic cfg(input logic [7:0] c1, input logic [15:0] a,
		input logic [7:0] p, input logic run);
		apb(1'b1, `ADDR_CTRL0, 32'h0);
		apb(1'b1, `ADDR_CTRL1, {24'h00_0000, c1});
		apb(1'b1, `ADDR_CMPA, {16'h0000, a});
		apb(1'b1, `ADDR_CMPP, {24'h00_0000, p});
		apb(1'b1, `ADDR_FLAGS, 32'h0000_0003);
		apb(1'b1, `ADDR_CTRL0, {31'h0, run});
		@(negedge ref_clk);
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		apb(1'b0, 12'h018, 32'h0);
		`CHK("unmapped", 1'b1, err_q)
		av = 16'h0110 + 16'(nxt() & 32'h0000_003F); // never zero
		cfg(8'h39, av, 8'h01, 1'b1);
		hold_len(tout, k);
		hold_len(tout, k);
		`CHK("toggle period", av + 16'h0001, 16'(k))
		apb(1'b0, `ADDR_FLAGS, 32'h0);
		`CHK("flags on a clear", 32'h0000_0001, rd_q)
		for (int f = 1; f < 3; f++) begin
			cfg({2'b00, 2'(f), f == 1, 3'b001}, av, 8'h01, 1'b1);
			repeat (3) @(negedge ref_clk);
			`CHK("initial level", f == 1, tout)
			hold_len(tout, k);
			`CHK("match level", f == 2, tout)
		end
		// A matches keep coming, but function 00 must leave the pin alone.
		cfg(8'h09, 16'h0020, 8'h01, 1'b1);
		repeat (180) @(negedge ref_clk);
		`CHK("no change level", 1'b1, tout)
		apb(1'b0, `ADDR_FLAGS, 32'h0);
		`CHK("no change flag", 32'h0000_0001, rd_q)
		cfg(8'hC0, 16'h0040, 8'h01, 1'b1);
		repeat (300) @(negedge ref_clk);
		apb(1'b0, `ADDR_FLAGS, 32'h0);
		`CHK("counter flags", 32'h0000_0003, rd_q)
		apb(1'b0, `ADDR_COUNT, 32'h0);
		`CHK("count span", 1'b1, rd_q < 32'h0000_0100)
		$display("compare done");
		for (int i = 0; i < 3; i++) begin
			av = (i == 1) ? 16'h0101 + 16'(nxt() & 32'h0000_00FF)
				: 16'h0008 + 16'(nxt() & 32'h0000_007F);
			w = (i == 1) ? av + 1 : span(8'h01);
			cfg(8'hA9 | {5'h00, i == 2, i == 1, 1'b0}, av, 8'h01, 1'b1);
			hold_len(tout, k);
			if (tout === 1'b0)
				hold_len(1'b0, k);
			hold_len(1'b1, hi);
			hold_len(1'b0, lo);
			`CHK("pwm active", duty(i, av, w), hi)
			`CHK("pwm period", w, hi + lo)
		end
		apb(1'b0, `ADDR_FLAGS, 32'h0);
		`CHK("pwm flags", 32'h0000_0003, rd_q)
		cfg(8'hA8, 16'h0100, 8'h01, 1'b1);
		repeat (300) @(negedge ref_clk);
		`CHK("full duty", 1'b1, tout)
		for (int j = 0; j < 2; j++) begin
			cfg(8'h89 | {3'h0, 1'(j), 4'h0}, 16'h0040, 8'h01, 1'b1);
			repeat (300) @(negedge ref_clk);
			`CHK("forced level", 1'(j), tout)
			apb(1'b0, `ADDR_FLAGS, 32'h0);
			`CHK("forced count", 32'h0000_0003, rd_q)
		end
		$display("pwm done");
		av = 16'h0120 + 16'(nxt() & 32'h0000_001F);
		cfg(8'hB8, av, 8'h01, 1'b0);
		far.flip(1'b0, 1'b1);
		@(negedge ref_clk);
		hold_len(1'b0, k);
		`CHK("pulse lead", 1'b1, tout)
		hold_len(1'b1, k);
		`CHK("pulse width", 1'b1, k + 8 >= av && k <= av + 2)
		apb(1'b0, `ADDR_CTRL0, 32'h0);
		`CHK("run cleared", 1'b0, rd_q[0])
		apb(1'b0, `ADDR_FLAGS, 32'h0);
		`CHK("pulse flag", 1'b1, rd_q[0])
		// Falling trigger selected: dropping the pin fires a second pulse.
		apb(1'b1, `ADDR_CTRL0, 32'h0000_0002);
		far.flip(1'b0, 1'b0);
		apb(1'b0, `ADDR_CTRL0, 32'h0);
		`CHK("falling trigger", 32'h0000_0003, rd_q)
		$display("pulse done");
		for (int f = 0; f < 3; f++) begin
			cfg({2'b01, 2'(f), 4'h0}, 16'h0000, 8'h00, 1'b1);
			w = 32'h0000_0014 + (nxt() & 32'h0000_003F);
			repeat (w) @(posedge ref_clk);
			far.flip(1'b1, !cap);
			apb(1'b0, `ADDR_CMPA, 32'h0);
			`CHK("captured", 1'b1, rd_q >= w && rd_q <= w + 12)
			apb(1'b0, `ADDR_FLAGS, 32'h0);
			`CHK("capture flag", 32'h0000_0001, rd_q)
		end
		cfg(8'h70, 16'h0000, 8'h01, 1'b1);
		far.flip(1'b1, 1'b0);
		far.flip(1'b1, 1'b1);
		apb(1'b0, `ADDR_CMPA, 32'h0);
		`CHK("no capture", 32'h0000_0000, rd_q)
		repeat (300) @(posedge ref_clk);
		apb(1'b0, `ADDR_FLAGS, 32'h0);
		`CHK("overflow", 32'h0000_0002, rd_q)
		$display("capture done");
		end_of_test();
	end
endmodule
